// File: core/pfe_core.sv
// filter selection, elapsed time counter and error status registers on apb
// Operation
// - counter two requester id, bits 31:24
// - counter one requester id, bits 15:8
// - counter two region code, bits 19:16
// - counter one region code, bits 3:0
// - region code 0 selects external memory
// - code 7 selects registers; others reserved
// - elapsed counter free-runs from reset
// - raw bit 5 single-bit ecc, w1s
// - raw bit 4 double-bit ecc, w1s
// - raw bit 3 write ecc, w1s
// - raw bit 0 command/address error, w1s
// - enabled bit 5 w1c clears raw too
// - enabled bit 4 w1c clears raw too
// - enabled bit 3 w1c clears raw too
// - enabled bit 0 w1c clears raw too
// - filters apply only when enabled
// - enable set register w1s enables
`timescale 1ns/100ps
module pfe_core #(
  parameter int ID_W = 8,
  parameter int REGION_W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [5:0] err_event,
  input wire logic access_valid,
  input wire logic [ID_W-1:0] access_id,
  input wire logic [REGION_W-1:0] access_region,
  output logic counter_one_hit,
  output logic counter_two_hit,
  output logic error_irq
);
  typedef enum logic [1:0] {
    PFE_IDLE = 2'b01,
    PFE_DONE = 2'b10
  } pfe_state_e;

  pfe_state_e state;
  pfe_state_e next_state;
  logic [7:0] counter_two_requester_id;
  logic [7:0] counter_one_requester_id;
  logic [3:0] counter_two_region_code;
  logic [3:0] counter_one_region_code;
  logic counter_two_requester_filter_on;
  logic counter_two_region_filter_on;
  logic counter_one_requester_filter_on;
  logic counter_one_region_filter_on;
  logic [31:0] elapsed_time_counter;
  logic [5:0] raw_flags;
  logic [5:0] enable_bits;

  wire access_phase;
  wire wr;
  wire rd;
  wire mapped;
  wire sel_cfg;
  wire sel_select;
  wire sel_elapsed;
  wire sel_raw;
  wire sel_enabled;
  wire sel_eset;
  wire sel_eclr;
  wire [5:0] wr_bits;
  wire [5:0] raw_set;
  wire [5:0] raw_clr;
  wire [5:0] next_raw;
  wire [5:0] next_enable;
  wire [5:0] enabled_flags;
  wire [31:0] select_word;
  wire [31:0] cfg_word;
  wire [31:0] next_rdata;
  wire c1_match;
  wire c2_match;

  // access phase with one wait state, pready registered; the state guards against a repeated commit
  assign access_phase = psel && penable && (state == PFE_IDLE);
  assign wr = access_phase && pwrite;
  assign rd = access_phase && !pwrite;
  assign sel_cfg = (paddr == pfe_pkg::OFF_FILTER_CFG);
  assign sel_select = (paddr == pfe_pkg::OFF_FILTER_SELECT);
  assign sel_elapsed = (paddr == pfe_pkg::OFF_ELAPSED);
  assign sel_raw = (paddr == pfe_pkg::OFF_RAW_FLAGS);
  assign sel_enabled = (paddr == pfe_pkg::OFF_ENABLED_FLAGS);
  assign sel_eset = (paddr == pfe_pkg::OFF_ENABLE_SET);
  assign sel_eclr = (paddr == pfe_pkg::OFF_ENABLE_CLEAR);
  assign mapped = sel_cfg || sel_select || sel_elapsed || sel_raw || sel_enabled
    || sel_eset || sel_eclr;
  assign wr_bits = pwdata[5:0] & pfe_pkg::ERR_MASK;

  assign raw_set = (wr && sel_raw) ? wr_bits : 6'h00;
  assign raw_clr = (wr && sel_enabled) ? wr_bits : 6'h00;
  // event and w1s win over a same-cycle clear
  assign next_raw = ((raw_flags & ~raw_clr) | raw_set | (err_event & pfe_pkg::ERR_MASK))
    & pfe_pkg::ERR_MASK;
  assign next_enable = ((enable_bits | ((wr && sel_eset) ? wr_bits : 6'h00))
    & ~((wr && sel_eclr) ? wr_bits : 6'h00)) & pfe_pkg::ERR_MASK;
  assign enabled_flags = raw_flags & enable_bits;

  assign select_word = {counter_two_requester_id, 4'h0, counter_two_region_code,
    counter_one_requester_id, 4'h0, counter_one_region_code};
  assign cfg_word = {counter_two_requester_filter_on, counter_two_region_filter_on, 14'h0000,
    counter_one_requester_filter_on, counter_one_region_filter_on, 14'h0000};
  assign next_rdata = sel_cfg ? cfg_word :
    sel_select ? select_word :
    sel_elapsed ? elapsed_time_counter :
    sel_raw ? {26'h000_0000, raw_flags} :
    sel_enabled ? {26'h000_0000, enabled_flags} :
    (sel_eset || sel_eclr) ? {26'h000_0000, enable_bits} : 32'h0000_0000;

  assign next_state = access_phase ? PFE_DONE : PFE_IDLE;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= PFE_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      state <= next_state;
      pready <= access_phase;
      pslverr <= access_phase && !mapped;
      prdata <= (rd && mapped) ? next_rdata : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      counter_two_requester_id <= pfe_pkg::RESET_ID;
      counter_one_requester_id <= pfe_pkg::RESET_ID;
      counter_two_region_code <= pfe_pkg::RESET_REGION;
      counter_one_region_code <= pfe_pkg::RESET_REGION;
    end
    else if (wr && sel_select)
    begin
      counter_two_requester_id <= pwdata[pfe_pkg::SEL_C2_ID_LSB +: 8];
      counter_one_requester_id <= pwdata[pfe_pkg::SEL_C1_ID_LSB +: 8];
      counter_two_region_code <= pwdata[pfe_pkg::SEL_C2_REGION_LSB +: 4];
      counter_one_region_code <= pwdata[pfe_pkg::SEL_C1_REGION_LSB +: 4];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      counter_two_requester_filter_on <= 1'b0;
      counter_two_region_filter_on <= 1'b0;
      counter_one_requester_filter_on <= 1'b0;
      counter_one_region_filter_on <= 1'b0;
    end
    else if (wr && sel_cfg)
    begin
      counter_two_requester_filter_on <= pwdata[pfe_pkg::CFG_C2_ID_ON_BIT];
      counter_two_region_filter_on <= pwdata[pfe_pkg::CFG_C2_REGION_ON_BIT];
      counter_one_requester_filter_on <= pwdata[pfe_pkg::CFG_C1_ID_ON_BIT];
      counter_one_region_filter_on <= pwdata[pfe_pkg::CFG_C1_REGION_ON_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      elapsed_time_counter <= pfe_pkg::RESET_ELAPSED;
      raw_flags <= pfe_pkg::RESET_FLAGS;
      enable_bits <= pfe_pkg::RESET_FLAGS;
      error_irq <= 1'b0;
      counter_one_hit <= 1'b0;
      counter_two_hit <= 1'b0;
    end
    else
    begin
      elapsed_time_counter <= elapsed_time_counter + 32'h0000_0001;
      raw_flags <= next_raw;
      enable_bits <= next_enable;
      error_irq <= |(next_raw & next_enable);
      counter_one_hit <= access_valid && c1_match;
      counter_two_hit <= access_valid && c2_match;
    end
  end

  pfe_match #(.ID_W(ID_W), .REGION_W(REGION_W)) u_match_one (
    .id_on(counter_one_requester_filter_on),
    .region_on(counter_one_region_filter_on),
    .id_want(counter_one_requester_id[ID_W-1:0]),
    .region_want(counter_one_region_code[REGION_W-1:0]),
    .access_id(access_id),
    .access_region(access_region),
    .hit(c1_match)
  );

  pfe_match #(.ID_W(ID_W), .REGION_W(REGION_W)) u_match_two (
    .id_on(counter_two_requester_filter_on),
    .region_on(counter_two_region_filter_on),
    .id_want(counter_two_requester_id[ID_W-1:0]),
    .region_want(counter_two_region_code[REGION_W-1:0]),
    .access_id(access_id),
    .access_region(access_region),
    .hit(c2_match)
  );

  elapsed_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) |-> elapsed_time_counter == $past(elapsed_time_counter) + 32'h0000_0001)
    else $error("elapsed counter did not step");
  raw_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && sel_raw && pwdata[pfe_pkg::ERR_SINGLE_BIT] |=> raw_flags[pfe_pkg::ERR_SINGLE_BIT])
    else $error("raw w1s lost");
  raw_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && sel_raw && raw_flags[pfe_pkg::ERR_DOUBLE_BIT] |=> raw_flags[pfe_pkg::ERR_DOUBLE_BIT])
    else $error("raw write cleared a flag");
  clear_both_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && sel_enabled && pwdata[pfe_pkg::ERR_WRITE_BIT] && !err_event[pfe_pkg::ERR_WRITE_BIT]
    |=> !raw_flags[pfe_pkg::ERR_WRITE_BIT])
    else $error("w1c did not clear raw");
  event_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
    err_event[pfe_pkg::ERR_CMD_ADDR_BIT] |=> raw_flags[pfe_pkg::ERR_CMD_ADDR_BIT])
    else $error("event lost against clear");
  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    error_irq == |enabled_flags)
    else $error("irq disagrees with enabled flags");
  enable_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && sel_eset && pwdata[pfe_pkg::ERR_SINGLE_BIT] && !(sel_eclr)
    |=> enable_bits[pfe_pkg::ERR_SINGLE_BIT])
    else $error("enable set ignored");
  select_rsvd_a: assert property (@(posedge pclk) disable iff (!presetn)
    select_word[23:20] == 4'h0 && select_word[7:4] == 4'h0)
    else $error("reserved select bits not zero");
  id_store_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && sel_select |=> counter_two_requester_id == $past(pwdata[31:24])
    && counter_one_region_code == $past(pwdata[3:0]))
    else $error("select fields not stored");
  ready_once_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready held two cycles");
  cov_irq_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(error_irq));
  cov_w1c_c: cover property (@(posedge pclk) disable iff (!presetn) wr && sel_enabled);
  cov_hit_c: cover property (@(posedge pclk) disable iff (!presetn)
    counter_two_hit && counter_two_region_filter_on);
endmodule : pfe_core

// File: pkg/pfe_pkg.sv
// package: register map, field layout and reset values of the filter and error status block
package pfe_pkg;
  localparam logic [11:0] OFF_FILTER_CFG = 12'h000;
  localparam logic [11:0] OFF_FILTER_SELECT = 12'h004;
  localparam logic [11:0] OFF_ELAPSED = 12'h008;
  localparam logic [11:0] OFF_RAW_FLAGS = 12'h00C;
  localparam logic [11:0] OFF_ENABLED_FLAGS = 12'h010;
  localparam logic [11:0] OFF_ENABLE_SET = 12'h014;
  localparam logic [11:0] OFF_ENABLE_CLEAR = 12'h018;
  localparam int SEL_C2_ID_LSB = 24;
  localparam int SEL_C2_REGION_LSB = 16;
  localparam int SEL_C1_ID_LSB = 8;
  localparam int SEL_C1_REGION_LSB = 0;
  localparam int CFG_C2_ID_ON_BIT = 31;
  localparam int CFG_C2_REGION_ON_BIT = 30;
  localparam int CFG_C1_ID_ON_BIT = 15;
  localparam int CFG_C1_REGION_ON_BIT = 14;
  localparam int ERR_SINGLE_BIT = 5;
  localparam int ERR_DOUBLE_BIT = 4;
  localparam int ERR_WRITE_BIT = 3;
  localparam int ERR_CMD_ADDR_BIT = 0;
  localparam logic [5:0] ERR_MASK = 6'h39;
  localparam logic [3:0] REGION_MEMORY = 4'h0;
  localparam logic [3:0] REGION_REGISTERS = 4'h7;
  localparam logic [7:0] RESET_ID = 8'h00;
  localparam logic [3:0] RESET_REGION = 4'h0;
  localparam logic [31:0] RESET_ELAPSED = 32'h0000_0000;
  localparam logic [5:0] RESET_FLAGS = 6'h00;
endpackage : pfe_pkg

// File: core/pfe_match.sv
// one counter's requester and region filter match
`timescale 1ns/100ps
module pfe_match #(
  parameter int ID_W = 8,
  parameter int REGION_W = 4
) (
  input wire logic id_on,
  input wire logic region_on,
  input wire logic [ID_W-1:0] id_want,
  input wire logic [REGION_W-1:0] region_want,
  input wire logic [ID_W-1:0] access_id,
  input wire logic [REGION_W-1:0] access_region,
  output logic hit
);
  wire id_ok;
  wire region_ok;
  assign id_ok = !id_on || (access_id == id_want);
  assign region_ok = !region_on || (access_region == region_want);
  assign hit = id_ok && region_ok;
endmodule : pfe_match

// File: verif/pfe_core_test.sv
// self-checking bench for the filter selection and error status block
`timescale 1ns/100ps
module pfe_core_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [5:0] err_event = 6'h00;
  logic access_valid = 1'b0;
  logic [7:0] access_id = 8'h00;
  logic [3:0] access_region = 4'h0;
  logic counter_one_hit;
  logic counter_two_hit;
  logic error_irq;
  int bad_count = 0;
  int comparisons = 0;

  always #20 pclk = ~pclk;

  pfe_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .err_event(err_event), .access_valid(access_valid),
    .access_id(access_id), .access_region(access_region),
    .counter_one_hit(counter_one_hit), .counter_two_hit(counter_two_hit),
    .error_irq(error_irq));

  task automatic report_and_stop();
    $display("errors %0d of %0d comparisons", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one apb transfer; holds the request until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20)
    begin
      bad_count++;
      report_and_stop();
    end
    else
    begin
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(q, exp);
  endtask : rchk

  // present one observed access, check both hits a cycle later
  task automatic probe(input logic [7:0] id, input logic [3:0] rg, input logic [1:0] exp);
    @(posedge pclk);
    access_valid <= 1'b1;
    access_id <= id;
    access_region <= rg;
    @(posedge pclk);
    access_valid <= 1'b0;
    #1;
    chk({30'h0, counter_two_hit, counter_one_hit}, {30'h0, exp});
  endtask : probe

  initial
  begin
    logic [31:0] q1;
    logic [31:0] q2;
    logic e;
    logic [31:0] m;
    int bits[4] = '{5, 4, 3, 0};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rchk(pfe_pkg::OFF_FILTER_SELECT, 32'h0000_0000);
    rchk(pfe_pkg::OFF_RAW_FLAGS, 32'h0000_0000);
    rchk(pfe_pkg::OFF_ENABLED_FLAGS, 32'h0000_0000);
    // only the two defined region codes are ever programmed
    wr(pfe_pkg::OFF_FILTER_SELECT, 32'hFFF7_FFF7);
    rchk(pfe_pkg::OFF_FILTER_SELECT, 32'hFF07_FF07);
    wr(pfe_pkg::OFF_FILTER_SELECT, 32'hA5F0_3CF7);
    rchk(pfe_pkg::OFF_FILTER_SELECT, 32'hA500_3C07);
    apb(1'b0, pfe_pkg::OFF_ELAPSED, 32'h0000_0000, q1, e);
    apb(1'b1, pfe_pkg::OFF_ELAPSED, 32'hFFFF_FFFF, q2, e);
    apb(1'b0, pfe_pkg::OFF_ELAPSED, 32'h0000_0000, q2, e);
    chk(q2 - q1, 32'h0000_0008);
    apb(1'b0, 12'h0FC, 32'h0000_0000, q1, e);
    chk(q1, 32'h0000_0000);
    chk({31'h0, e}, 32'h0000_0001);
    wr(pfe_pkg::OFF_ENABLE_SET, 32'hFFFF_FFFF);
    rchk(pfe_pkg::OFF_ENABLE_SET, 32'h0000_0039);
    foreach (bits[i])
    begin
      m = 32'h0000_0001 << bits[i];
      @(posedge pclk);
      err_event <= m[5:0];
      @(posedge pclk);
      err_event <= 6'h00;
      rchk(pfe_pkg::OFF_RAW_FLAGS, m);
      rchk(pfe_pkg::OFF_ENABLED_FLAGS, m);
      chk({31'h0, error_irq}, 32'h0000_0001);
      wr(pfe_pkg::OFF_ENABLED_FLAGS, ~m);
      rchk(pfe_pkg::OFF_RAW_FLAGS, m);
      wr(pfe_pkg::OFF_ENABLED_FLAGS, m);
      rchk(pfe_pkg::OFF_RAW_FLAGS, 32'h0000_0000);
      chk({31'h0, error_irq}, 32'h0000_0000);
      wr(pfe_pkg::OFF_RAW_FLAGS, m);
      wr(pfe_pkg::OFF_RAW_FLAGS, 32'h0000_0000);
      rchk(pfe_pkg::OFF_ENABLED_FLAGS, m);
      wr(pfe_pkg::OFF_ENABLED_FLAGS, m);
    end
    wr(pfe_pkg::OFF_ENABLE_CLEAR, 32'h0000_0010);
    rchk(pfe_pkg::OFF_ENABLE_SET, 32'h0000_0029);
    wr(pfe_pkg::OFF_RAW_FLAGS, 32'h0000_0010);
    rchk(pfe_pkg::OFF_ENABLED_FLAGS, 32'h0000_0000);
    chk({31'h0, error_irq}, 32'h0000_0000);
    wr(pfe_pkg::OFF_ENABLE_SET, 32'h0000_0010);
    rchk(pfe_pkg::OFF_ENABLED_FLAGS, 32'h0000_0010);
    wr(pfe_pkg::OFF_ENABLED_FLAGS, 32'h0000_0010);
    // event held through a clearing write must survive it
    @(posedge pclk);
    err_event <= 6'h20;
    wr(pfe_pkg::OFF_ENABLED_FLAGS, 32'h0000_0020);
    err_event <= 6'h00;
    rchk(pfe_pkg::OFF_RAW_FLAGS, 32'h0000_0020);
    // counter two wants id 5a in registers, counter one id 3c in memory
    wr(pfe_pkg::OFF_FILTER_SELECT, 32'h5A07_3C00);
    wr(pfe_pkg::OFF_FILTER_CFG, 32'h0000_0000);
    probe(8'h11, 4'h3, 2'b11);
    wr(pfe_pkg::OFF_FILTER_CFG, 32'hFFFF_FFFF);
    rchk(pfe_pkg::OFF_FILTER_CFG, 32'hC000_C000);
    probe(8'h5A, pfe_pkg::REGION_REGISTERS, 2'b10);
    probe(8'h3C, pfe_pkg::REGION_MEMORY, 2'b01);
    probe(8'h5A, pfe_pkg::REGION_MEMORY, 2'b00);
    wr(pfe_pkg::OFF_FILTER_CFG, 32'hC000_0000);
    probe(8'h5A, pfe_pkg::REGION_REGISTERS, 2'b11);
    probe(8'h5A, pfe_pkg::REGION_MEMORY, 2'b01);
    wr(pfe_pkg::OFF_FILTER_CFG, 32'h4000_4000);
    probe(8'h00, pfe_pkg::REGION_REGISTERS, 2'b10);
    report_and_stop();
  end
endmodule : pfe_core_test
